// file: core/ckb_byte_window.sv
// ckb_byte_window: picks a run of bytes out of a frame byte window
// assumes: byte 0 of the window sits in the low bits; output byte 0 in the high bits
`timescale 1ns/1ps
module ckb_byte_window #(
  parameter int WIN_BYTES = 64,
  parameter int OUT_BYTES = 4,
  parameter int OFS_W = 6
) (
  // window and start position
  input wire logic [WIN_BYTES*8-1:0] win,
  input wire logic [OFS_W-1:0] offset,
  // selected bytes, first byte most significant
  output logic [OUT_BYTES*8-1:0] bytes_out
);

  if (OUT_BYTES < 1 || OUT_BYTES > WIN_BYTES || WIN_BYTES > (1 << OFS_W)) begin : g_bad
    $error("ckb_byte_window: unusable sizes");
  end

  for (genvar k = 0; k < OUT_BYTES; k++) begin : g_byte
    logic [OFS_W:0] pos;
    logic in_win;
    assign pos = {1'b0, offset} + (OFS_W + 1)'(k);
    assign in_win = (int'(pos) < WIN_BYTES);
    // bytes past the window read as zero
    assign bytes_out[(OUT_BYTES-1-k)*8 +: 8] = in_win ? win[8*pos +: 8] : 8'h00;
  end

endmodule // ckb_byte_window

// file: core/ckb_key_builder.sv
// ckb_key_builder: builds the tail fields of the narrower wide key and the head
// fields of the wider key for the ingress classification lookup
// assumes: parser results, action context and requests come from core-clock logic
//
// Notes on behaviour
// - dscp field is frame dscp, or classified dscp when enabled
// - dest address field is ipv4 dip, or ipv6 dip bits 31:0
// - llc frames: source field is control byte then payload bytes 0-2
// - snap frames: source field is pid bytes 2..0 then payload byte 0
// - ip frames: source field is ipv4 sip, or ipv6 sip bits 31:0
// - other ethertype frames: source field is payload bytes 0-3
// - protocol field is ipv4 protocol, or ipv6 next header
// - range mask carries range checker results, dscp checker on remapped dscp
// - ip payload word starts 20 bytes after l3 header start, options ignored
// - custom field is 15 bytes from current frame pointer
// - ethernet pointer skips both macs, 0-3 vlan tags and ethertype
// - key type selector: 0 full ll, 1 normal, 2 ipv4 five-tuple, 3 custom
// - first flag set on first lookup, clear on second
// - logical ingress port appears only in full low-latency key
// - service flag set when previous action chose service index, except in full low-latency key
// - generic index follows next-index control and value of previous action, zero in full low-latency key
// - without prior action, index defaults to zero, logical or masqueraded port
`timescale 1ns/1ps
module ckb_key_builder
  import ckb_pkg::*;
#(
  parameter int FRAME_BYTES = CKB_FRAME_BYTES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [CKB_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // frame parser results
  input wire ckb_frame_info_t frame_info,
  input wire logic [FRAME_BYTES*8-1:0] frame_bytes,
  // previous lookup action and port context
  input wire ckb_prev_action_t prev_action,
  input wire logic [CKB_PORT_W-1:0] masq_port_number,
  // lookup request
  input wire ckb_lookup_req_t lookup_req,
  // key towards the lookup memory
  output ckb_key_t key_out,
  output logic key_valid
);

  if (FRAME_BYTES < CKB_CUSTOM_BYTES || FRAME_BYTES > (1 << CKB_OFS_W)) begin : g_bad
    $error("ckb_key_builder: FRAME_BYTES out of range");
  end

  // ---------------- reset release
  logic rst_n_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_n_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_n_meta_reg <= 1'b1;
      rst_n_reg <= rst_n_meta_reg;
    end
  end

  // ---------------- configuration registers
  logic use_classified_dscp_en_reg;
  logic use_classified_dscp_en_next;
  logic [1:0] default_chain_index_sel_reg;
  logic [1:0] default_chain_index_sel_next;
  logic [CKB_PORT_W-1:0] logical_port_number_cfg_reg;
  logic [CKB_PORT_W-1:0] logical_port_number_cfg_next;

  wire wr_ctrl = reg_wr && (reg_addr == CKB_REG_CTRL);
  wire wr_port = reg_wr && (reg_addr == CKB_REG_PORT);

  assign use_classified_dscp_en_next = wr_ctrl ? reg_wdata[CKB_CTRL_DSCP_BIT]
                                               : use_classified_dscp_en_reg;
  assign default_chain_index_sel_next = wr_ctrl ? reg_wdata[CKB_CTRL_GSEL_LSB +: 2]
                                                : default_chain_index_sel_reg;
  assign logical_port_number_cfg_next = wr_port ? reg_wdata[CKB_PORT_W-1:0]
                                                : logical_port_number_cfg_reg;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      use_classified_dscp_en_reg <= CKB_DSCP_EN_RESET;
      default_chain_index_sel_reg <= CKB_GSEL_RESET;
      logical_port_number_cfg_reg <= CKB_LPORT_RESET;
    end else begin
      use_classified_dscp_en_reg <= use_classified_dscp_en_next;
      default_chain_index_sel_reg <= default_chain_index_sel_next;
      logical_port_number_cfg_reg <= logical_port_number_cfg_next;
    end
  end

  // ---------------- frame classes
  wire is_llc = !frame_info.ethertype_frame_flag && !frame_info.ip_or_snap_flag;
  wire is_snap = !frame_info.ethertype_frame_flag && frame_info.ip_or_snap_flag;
  wire is_ip = frame_info.ethertype_frame_flag && frame_info.ip_or_snap_flag;
  wire is_other = frame_info.ethertype_frame_flag && !frame_info.ip_or_snap_flag;
  wire is_ipv4 = is_ip && frame_info.ipv4_frame_flag;
  wire is_ipv6 = is_ip && !frame_info.ipv4_frame_flag;

  // ---------------- byte positions
  logic [CKB_OFS_W-1:0] eth_layer_end;
  logic [CKB_OFS_W-1:0] custom_start;
  logic [CKB_OFS_W-1:0] ip_payload_start;
  logic [CKB_OFS_W-1:0] vlan_bytes;

  // vlan count 0..3 times tag length
  assign vlan_bytes = CKB_OFS_W'(frame_info.vlan_count * CKB_VLAN_TAG_BYTES);
  assign eth_layer_end = CKB_OFS_W'(CKB_MAC_PAIR_BYTES + CKB_ETYPE_BYTES) + vlan_bytes;
  assign custom_start = frame_info.frame_ptr_is_eth ? eth_layer_end : frame_info.frame_ptr;
  // fixed ipv4 header length, options never parsed
  assign ip_payload_start = frame_info.l3_hdr_offset + CKB_OFS_W'(CKB_IPV4_HDR_BYTES);

  // ---------------- byte pickers
  logic [CKB_CUSTOM_BYTES*8-1:0] custom_raw;
  logic [CKB_WORD_BYTES*8-1:0] ip_payload_raw;
  logic [CKB_WORD_BYTES*8-1:0] payload_raw;

  ckb_byte_window #(
    .WIN_BYTES(FRAME_BYTES),
    .OUT_BYTES(CKB_CUSTOM_BYTES),
    .OFS_W(CKB_OFS_W)
  ) u_custom (
    .win(frame_bytes),
    .offset(custom_start),
    .bytes_out(custom_raw)
  );

  ckb_byte_window #(
    .WIN_BYTES(FRAME_BYTES),
    .OUT_BYTES(CKB_WORD_BYTES),
    .OFS_W(CKB_OFS_W)
  ) u_ip_payload (
    .win(frame_bytes),
    .offset(ip_payload_start),
    .bytes_out(ip_payload_raw)
  );

  ckb_byte_window #(
    .WIN_BYTES(FRAME_BYTES),
    .OUT_BYTES(CKB_WORD_BYTES),
    .OFS_W(CKB_OFS_W)
  ) u_payload (
    .win(frame_bytes),
    .offset(frame_info.payload_offset),
    .bytes_out(payload_raw)
  );

  // ---------------- narrow-family fields
  logic [5:0] dscp_sel;
  logic [5:0] dscp_field;
  logic [31:0] dest_field;
  logic [31:0] src_llc;
  logic [31:0] src_snap;
  logic [31:0] src_ip;
  logic [31:0] src_field;
  logic [7:0] proto_field;
  logic [31:0] ip_payload_field;

  assign dscp_sel = use_classified_dscp_en_reg ? frame_info.classified_dscp
                                               : frame_info.frame_dscp;
  assign dscp_field = is_ip ? dscp_sel : 6'h00;

  assign dest_field = is_ipv4 ? frame_info.ipv4_dip :
                      is_ipv6 ? frame_info.ipv6_dip_low : 32'h0000_0000;

  assign src_llc = {frame_info.llc_ctrl, payload_raw[31:8]};
  assign src_snap = {frame_info.snap_pid, payload_raw[31:24]};
  assign src_ip = frame_info.ipv4_frame_flag ? frame_info.ipv4_sip
                                             : frame_info.ipv6_sip_low;

  // the four frame classes cover every flag pair
  assign src_field = is_llc ? src_llc :
                     is_snap ? src_snap :
                     is_ip ? src_ip :
                     payload_raw;

  assign proto_field = is_ipv4 ? frame_info.ip_proto :
                       is_ipv6 ? frame_info.ipv6_next_hdr : 8'h00;

  assign ip_payload_field = is_ip ? ip_payload_raw : 32'h0000_0000;

  // ---------------- wide-family head fields
  logic is_full_ll;
  logic use_prev;
  logic [CKB_GIDX_W-1:0] default_index;
  logic [CKB_GIDX_W-1:0] chained_index;
  logic chained_service;
  logic [CKB_GIDX_W-1:0] gen_index_val;
  logic gen_service_val;

  assign is_full_ll = (lookup_req.key_type == CKB_KT_FULL_LL);
  // a first lookup has no earlier action to chain from
  assign use_prev = prev_action.valid && !lookup_req.first;

  always_comb begin
    case (ckb_gsel_t'(default_chain_index_sel_reg))
      CKB_GSEL_ZERO: begin
        default_index = '0;
      end
      CKB_GSEL_LPORT: begin
        default_index = {{(CKB_GIDX_W-CKB_PORT_W){1'b0}}, logical_port_number_cfg_reg};
      end
      CKB_GSEL_MASQ: begin
        default_index = {{(CKB_GIDX_W-CKB_PORT_W){1'b0}}, masq_port_number};
      end
      default: begin
        default_index = '0;
      end
    endcase
  end

  always_comb begin
    chained_service = 1'b0;
    case (prev_action.next_index_control)
      CKB_NIC_NONE: begin
        chained_index = default_index;
      end
      CKB_NIC_REPLACE: begin
        chained_index = prev_action.next_index_value;
      end
      CKB_NIC_ADD: begin
        chained_index = CKB_GIDX_W'(prev_action.prev_gen_index + prev_action.next_index_value);
      end
      CKB_NIC_SERVICE: begin
        chained_index = prev_action.service_index;
        chained_service = 1'b1;
      end
      default: begin
        chained_index = default_index;
      end
    endcase
  end

  assign gen_index_val = is_full_ll ? '0 :
                         use_prev ? chained_index : default_index;
  assign gen_service_val = !is_full_ll && use_prev && chained_service;

  // ---------------- key assembly
  ckb_key_t key_next;
  ckb_key_t key_reg;
  logic key_valid_reg;

  always_comb begin
    key_next = key_reg;
    if (lookup_req.req) begin
      key_next.wide_key_type_sel = lookup_req.key_type;
      key_next.first_lookup = lookup_req.first;
      key_next.key_logical_in_port = is_full_ll ? logical_port_number_cfg_reg : '0;
      key_next.gen_index_from_service = gen_service_val;
      key_next.gen_index = gen_index_val;
      key_next.key_dscp_field = dscp_field;
      key_next.key_dest_addr_field = dest_field;
      key_next.key_src_addr_field = src_field;
      key_next.key_protocol_field = proto_field;
      key_next.key_range_mask = frame_info.range_results;
      key_next.key_ip_payload_word = ip_payload_field;
      key_next.key_custom_bytes = custom_raw;
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      key_reg <= '0;
      key_valid_reg <= 1'b0;
    end else begin
      key_reg <= key_next;
      key_valid_reg <= lookup_req.req;
    end
  end

  assign key_out = key_reg;
  assign key_valid = key_valid_reg;

  // ---------------- activity status
  logic [15:0] key_count_reg;
  logic [15:0] key_count_next;

  assign key_count_next = lookup_req.req ? 16'(key_count_reg + 16'h0001) : key_count_reg;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      key_count_reg <= CKB_COUNT_RESET;
    end else begin
      key_count_reg <= key_count_next;
    end
  end

  // ---------------- register read
  logic [31:0] ctrl_view;
  logic [31:0] port_view;
  logic [31:0] status_view;
  logic [31:0] read_sel;
  logic [31:0] reg_rdata_reg;
  logic [31:0] reg_rdata_next;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[CKB_CTRL_DSCP_BIT] = use_classified_dscp_en_reg;
    ctrl_view[CKB_CTRL_GSEL_LSB +: 2] = default_chain_index_sel_reg;
  end

  assign port_view = {{(32-CKB_PORT_W){1'b0}}, logical_port_number_cfg_reg};

  always_comb begin
    status_view = '0;
    status_view[15:0] = key_count_reg;
    status_view[CKB_STAT_TYPE_LSB +: 2] = key_reg.wide_key_type_sel;
    status_view[CKB_STAT_SVC_BIT] = key_reg.gen_index_from_service;
    status_view[CKB_STAT_FIRST_BIT] = key_reg.first_lookup;
  end

  // unmapped offsets read as zero
  assign read_sel = (reg_addr == CKB_REG_CTRL) ? ctrl_view :
                    (reg_addr == CKB_REG_PORT) ? port_view :
                    (reg_addr == CKB_REG_STATUS) ? status_view : 32'h0000_0000;

  assign reg_rdata_next = reg_rd ? read_sel : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reg_rdata_reg <= 32'h0000_0000;
    end else begin
      reg_rdata_reg <= reg_rdata_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;

endmodule // ckb_key_builder

// file: include/ckb_pkg.sv
// ckb_pkg: constants, enumerations and carrier structs for the key field builder
// assumes: everything runs on the switch core clock; parser and action logic share it
package ckb_pkg;

  // frame byte window seen by the builder
  localparam int CKB_FRAME_BYTES = 64;
  localparam int CKB_OFS_W = 6;

  // field widths
  localparam int CKB_CUSTOM_BYTES = 15;
  localparam int CKB_WORD_BYTES = 4;
  localparam int CKB_GIDX_W = 12;
  localparam int CKB_PORT_W = 6;

  // layer positions in bytes
  localparam int CKB_MAC_PAIR_BYTES = 12;
  localparam int CKB_VLAN_TAG_BYTES = 4;
  localparam int CKB_ETYPE_BYTES = 2;
  localparam int CKB_IPV4_HDR_BYTES = 20;

  // register port
  localparam int CKB_ADDR_W = 4;
  localparam logic [CKB_ADDR_W-1:0] CKB_REG_CTRL = 4'h0;
  localparam logic [CKB_ADDR_W-1:0] CKB_REG_PORT = 4'h4;
  localparam logic [CKB_ADDR_W-1:0] CKB_REG_STATUS = 4'h8;

  // control and status register fields
  localparam int CKB_CTRL_DSCP_BIT = 0;
  localparam int CKB_CTRL_GSEL_LSB = 1;
  localparam int CKB_STAT_TYPE_LSB = 16;
  localparam int CKB_STAT_SVC_BIT = 18;
  localparam int CKB_STAT_FIRST_BIT = 19;

  // values after reset
  localparam logic CKB_DSCP_EN_RESET = 1'b0;
  localparam logic [1:0] CKB_GSEL_RESET = 2'h0;
  localparam logic [CKB_PORT_W-1:0] CKB_LPORT_RESET = 6'h00;
  localparam logic [15:0] CKB_COUNT_RESET = 16'h0000;

  // wide key type selector
  typedef enum logic [1:0] {
    CKB_KT_FULL_LL = 2'h0,
    CKB_KT_NORMAL = 2'h1,
    CKB_KT_NORMAL_IP4 = 2'h2,
    CKB_KT_CUSTOM2 = 2'h3
  } ckb_key_type_t;

  // default chain index source
  typedef enum logic [1:0] {
    CKB_GSEL_ZERO = 2'h0,
    CKB_GSEL_LPORT = 2'h1,
    CKB_GSEL_MASQ = 2'h2
  } ckb_gsel_t;

  // next index control from the previous action
  typedef enum logic [1:0] {
    CKB_NIC_NONE = 2'h0,
    CKB_NIC_REPLACE = 2'h1,
    CKB_NIC_ADD = 2'h2,
    CKB_NIC_SERVICE = 2'h3
  } ckb_nic_t;

  typedef struct packed {
    logic ethertype_frame_flag;
    logic ip_or_snap_flag;
    logic ipv4_frame_flag;
    logic frame_ptr_is_eth;
    logic [1:0] vlan_count;
    logic [CKB_OFS_W-1:0] frame_ptr;
    logic [CKB_OFS_W-1:0] l3_hdr_offset;
    logic [CKB_OFS_W-1:0] payload_offset;
    logic [5:0] frame_dscp;
    logic [5:0] classified_dscp;
    logic [31:0] ipv4_sip;
    logic [31:0] ipv4_dip;
    logic [31:0] ipv6_sip_low;
    logic [31:0] ipv6_dip_low;
    logic [7:0] ip_proto;
    logic [7:0] ipv6_next_hdr;
    logic [7:0] llc_ctrl;
    logic [23:0] snap_pid;
    logic [7:0] range_results;
  } ckb_frame_info_t;

  typedef struct packed {
    logic valid;
    ckb_nic_t next_index_control;
    logic [CKB_GIDX_W-1:0] next_index_value;
    logic [CKB_GIDX_W-1:0] service_index;
    logic [CKB_GIDX_W-1:0] prev_gen_index;
  } ckb_prev_action_t;

  typedef struct packed {
    logic req;
    ckb_key_type_t key_type;
    logic first;
  } ckb_lookup_req_t;

  typedef struct packed {
    ckb_key_type_t wide_key_type_sel;
    logic first_lookup;
    logic [CKB_PORT_W-1:0] key_logical_in_port;
    logic gen_index_from_service;
    logic [CKB_GIDX_W-1:0] gen_index;
    logic [5:0] key_dscp_field;
    logic [31:0] key_dest_addr_field;
    logic [31:0] key_src_addr_field;
    logic [7:0] key_protocol_field;
    logic [7:0] key_range_mask;
    logic [31:0] key_ip_payload_word;
    logic [CKB_CUSTOM_BYTES*8-1:0] key_custom_bytes;
  } ckb_key_t;

endpackage

// file: test/ckb_key_builder_sva.sv
// ckb_key_builder_sva: port-level assertions for the key field builder
// assumes: bound into ckb_key_builder, one core clock, nrst active low
`timescale 1ns/1ps
module ckb_key_builder_sva
  import ckb_pkg::*;
#(
  parameter int FRAME_BYTES = CKB_FRAME_BYTES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [CKB_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // lookup side
  input wire ckb_frame_info_t frame_info,
  input wire logic [FRAME_BYTES*8-1:0] frame_bytes,
  input wire ckb_prev_action_t prev_action,
  input wire logic [CKB_PORT_W-1:0] masq_port_number,
  input wire ckb_lookup_req_t lookup_req,
  input wire ckb_key_t key_out,
  input wire logic key_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire ip_frame = frame_info.ethertype_frame_flag && frame_info.ip_or_snap_flag;
  wire chain_svc = lookup_req.req && !lookup_req.first && prev_action.valid
    && prev_action.next_index_control == CKB_NIC_SERVICE && lookup_req.key_type != CKB_KT_FULL_LL;

  chk_valid_after_req: assert property (lookup_req.req |=> key_valid)
    else $error("key_valid missing after request");
  chk_valid_single: assert property (!lookup_req.req |=> !key_valid)
    else $error("key_valid without request");
  chk_type_first: assert property (lookup_req.req |=> key_out.wide_key_type_sel == $past(lookup_req.key_type)
    && key_out.first_lookup == $past(lookup_req.first)) else $error("type or first flag wrong");
  chk_port_ll_only: assert property (key_valid && key_out.wide_key_type_sel != CKB_KT_FULL_LL
    |-> key_out.key_logical_in_port == '0) else $error("port field outside full key");
  chk_ll_no_index: assert property (key_valid && key_out.wide_key_type_sel == CKB_KT_FULL_LL
    |-> key_out.gen_index == '0 && !key_out.gen_index_from_service) else $error("index in full key");
  chk_ipv4_fields: assert property (lookup_req.req && ip_frame && frame_info.ipv4_frame_flag
    |=> key_out.key_dest_addr_field == $past(frame_info.ipv4_dip) && key_out.key_src_addr_field
    == $past(frame_info.ipv4_sip) && key_out.key_protocol_field == $past(frame_info.ip_proto))
    else $error("ipv4 fields wrong");
  chk_ipv6_fields: assert property (lookup_req.req && ip_frame && !frame_info.ipv4_frame_flag
    |=> key_out.key_dest_addr_field == $past(frame_info.ipv6_dip_low) && key_out.key_src_addr_field
    == $past(frame_info.ipv6_sip_low) && key_out.key_protocol_field == $past(frame_info.ipv6_next_hdr))
    else $error("ipv6 fields wrong");
  chk_range_pass: assert property (lookup_req.req |=> key_out.key_range_mask == $past(frame_info.range_results))
    else $error("range mask wrong");
  chk_svc_index: assert property (chain_svc |=> key_out.gen_index_from_service
    && key_out.gen_index == $past(prev_action.service_index)) else $error("service index not used");
  chk_key_hold: assert property (!lookup_req.req |=> $stable(key_out))
    else $error("key changed without request");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read slot");

  cover property (lookup_req.req && lookup_req.key_type == CKB_KT_CUSTOM2);
  cover property (chain_svc);
  cover property (reg_rd && reg_addr == CKB_REG_STATUS);
endmodule // ckb_key_builder_sva

// file: test/ckb_lookup_mem_model.sv
// ckb_lookup_mem_model: stand-in for the lookup memory, takes every key presented
// assumes: key_valid is a one-cycle pulse with key_out settled beside it
`timescale 1ns/1ps
module ckb_lookup_mem_model
  import ckb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // key from the builder
  input wire ckb_key_t key_out,
  input wire logic key_valid,
  // what was taken
  output logic [15:0] keys_taken,
  output ckb_key_t last_key
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      keys_taken <= 16'h0000;
      last_key <= '0;
    end else if (key_valid) begin
      keys_taken <= keys_taken + 16'h0001;
      last_key <= key_out;
    end
  end
endmodule // ckb_lookup_mem_model

// file: test/tb.sv
// tb: self-checking bench for ckb_key_builder with a lookup memory stand-in
// assumes: ckb_pkg compiled first; checker bound at the foot of this file
`timescale 1ns/1ps
module tb;
  import ckb_pkg::*;
  logic clk;
  logic nrst;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  ckb_frame_info_t frame_info;
  logic [511:0] frame_bytes;
  ckb_prev_action_t prev_action;
  logic [5:0] masq_port_number;
  ckb_lookup_req_t lookup_req;
  ckb_key_t key_out;
  logic key_valid;
  logic [15:0] keys_taken;
  ckb_key_t last_key;
  int error_cnt;
  int cmp_count;
  int nkeys;

  ckb_key_builder #(.FRAME_BYTES(64)) u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_info(frame_info), .frame_bytes(frame_bytes), .prev_action(prev_action),
    .masq_port_number(masq_port_number), .lookup_req(lookup_req), .key_out(key_out), .key_valid(key_valid));
  ckb_lookup_mem_model u_mem (.clk(clk), .nrst(nrst), .key_out(key_out), .key_valid(key_valid),
    .keys_taken(keys_taken), .last_key(last_key));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // n bytes from offset o, first byte most significant, past the window reads 0
  function automatic logic [127:0] win(input int o, input int n);
    logic [127:0] r;
    r = '0;
    for (int k = 0; k < n; k++) r = {r[119:0], (o + k < 64) ? 8'(o + k + 64) : 8'h00};
    return r;
  endfunction

  function automatic ckb_frame_info_t base_fi();
    return '{1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 6'h14, 6'h0e, 6'h16, 6'h2d, 6'h12, 32'hc0a80101, 32'h0a000002,
      32'h11223344, 32'h55667788, 8'h11, 8'h3a, 8'h03, 24'habcdef, 8'h5a};
  endfunction

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic lookup(input ckb_frame_info_t f, input ckb_prev_action_t p, input ckb_key_type_t t,
    input logic first);
    @(posedge clk);
    frame_info <= f;
    prev_action <= p;
    lookup_req <= '{1'b1, t, first};
    @(posedge clk);
    lookup_req.req <= 1'b0;
    @(negedge clk);
    check(key_valid, 1'b1);
    nkeys++;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    reg_read(CKB_REG_CTRL, d);
    check(d, 32'h0);
    reg_read(CKB_REG_PORT, d);
    check(d, 32'h0);
    reg_write(CKB_REG_CTRL, 32'h7);
    reg_read(CKB_REG_CTRL, d);
    check(d, 32'h7);
    reg_write(CKB_REG_STATUS, 32'hffffffff);
    reg_read(CKB_REG_STATUS, d);
    check(d, 32'h0);
    reg_read(4'hc, d);
    check(d, 32'h0);
    reg_write(CKB_REG_CTRL, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_ip;
    ckb_frame_info_t f;
    f = base_fi();
    for (int v = 0; v < 2; v++) begin
      f.ipv4_frame_flag = v[0];
      lookup(f, '0, CKB_KT_NORMAL, 1'b1);
      check(key_out.key_dest_addr_field, v ? f.ipv4_dip : f.ipv6_dip_low);
      check(key_out.key_src_addr_field, v ? f.ipv4_sip : f.ipv6_sip_low);
      check(key_out.key_protocol_field, v ? f.ip_proto : f.ipv6_next_hdr);
      check(key_out.key_ip_payload_word, win(34, 4));
      check(key_out.key_range_mask, f.range_results);
      check(key_out.key_dscp_field, f.frame_dscp);
    end
    reg_write(CKB_REG_CTRL, 32'h1);
    lookup(f, '0, CKB_KT_NORMAL_IP4, 1'b0);
    check(key_out.key_dscp_field, f.classified_dscp);
    reg_write(CKB_REG_CTRL, 32'h0);
    $display("t_ip done");
  endtask

  task automatic t_src;
    ckb_frame_info_t f;
    logic [127:0] w;
    logic [31:0] e [3];
    f = base_fi();
    w = win(22, 4);
    e = '{{f.llc_ctrl, w[31:8]}, {f.snap_pid, w[31:24]}, w[31:0]};
    for (int m = 0; m < 3; m++) begin
      f.ethertype_frame_flag = (m == 2);
      f.ip_or_snap_flag = (m == 1);
      lookup(f, '0, CKB_KT_NORMAL, 1'b1);
      check(key_out.key_src_addr_field, e[m]);
      check({key_out.key_dest_addr_field, key_out.key_protocol_field}, 40'h0);
      check({key_out.key_ip_payload_word, key_out.key_dscp_field}, 38'h0);
    end
    $display("t_src done");
  endtask

  task automatic t_custom;
    ckb_frame_info_t f;
    f = base_fi();
    f.frame_ptr_is_eth = 1'b1;
    for (int v = 0; v < 4; v++) begin
      f.vlan_count = v[1:0];
      lookup(f, '0, CKB_KT_CUSTOM2, 1'b1);
      check(key_out.key_custom_bytes, win(14 + 4 * v, 15));
    end
    f.frame_ptr_is_eth = 1'b0;
    f.frame_ptr = 6'h37;
    lookup(f, '0, CKB_KT_CUSTOM2, 1'b0);
    check(key_out.key_custom_bytes, win(55, 15));
    $display("t_custom done");
  endtask

  task automatic t_chain;
    logic [11:0] gexp [4];
    logic [11:0] dexp [4];
    logic [31:0] d;
    gexp = '{12'h02a, 12'h123, 12'h113, 12'h456};
    dexp = '{12'h000, 12'h02a, 12'h015, 12'h000};
    reg_write(CKB_REG_PORT, 32'h2a);
    for (int t = 0; t < 4; t++) begin
      lookup(base_fi(), '0, ckb_key_type_t'(t), t[0]);
      check(key_out.wide_key_type_sel, t[1:0]);
      check(key_out.first_lookup, t[0]);
      check(key_out.key_logical_in_port, (t == 0) ? 6'h2a : 6'h00);
    end
    for (int s = 0; s < 4; s++) begin
      reg_write(CKB_REG_CTRL, 32'(s) << 1);
      lookup(base_fi(), '0, CKB_KT_NORMAL, 1'b1);
      check(key_out.gen_index, dexp[s]);
    end
    reg_write(CKB_REG_CTRL, 32'h2);
    for (int c = 0; c < 4; c++) begin
      lookup(base_fi(), '{1'b1, ckb_nic_t'(c), 12'h123, 12'h456, 12'hff0}, CKB_KT_NORMAL_IP4, 1'b0);
      check(key_out.gen_index, gexp[c]);
      check(key_out.gen_index_from_service, c == 3);
    end
    lookup(base_fi(), '{1'b1, CKB_NIC_SERVICE, 12'h123, 12'h456, 12'hff0}, CKB_KT_FULL_LL, 1'b0);
    check({key_out.gen_index_from_service, key_out.gen_index}, 13'h0000);
    check(key_out.key_logical_in_port, 6'h2a);
    lookup(base_fi(), '{1'b1, CKB_NIC_SERVICE, 12'h123, 12'h456, 12'hff0}, CKB_KT_NORMAL, 1'b1);
    check({key_out.gen_index_from_service, key_out.gen_index}, 13'h002a);
    reg_read(CKB_REG_STATUS, d);
    check(d[19:0], {4'h9, 16'(nkeys)});
    $display("t_chain done");
  endtask

  initial begin
    nrst = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_info = '0;
    prev_action = '0;
    lookup_req = '0;
    masq_port_number = 6'h15;
    for (int i = 0; i < 64; i++) frame_bytes[8*i +: 8] = 8'(i + 64);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_ip;
    t_src;
    t_custom;
    t_chain;
    check(keys_taken, 16'(nkeys));
    summarize;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize;
  end
endmodule // tb

bind ckb_key_builder ckb_key_builder_sva #(.FRAME_BYTES(FRAME_BYTES)) u_sva (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .frame_info(frame_info), .frame_bytes(frame_bytes), .prev_action(prev_action),
  .masq_port_number(masq_port_number), .lookup_req(lookup_req), .key_out(key_out), .key_valid(key_valid));
